/* inc/srre_regs.vh */
`ifndef SRRE_REGS_VH
`define SRRE_REGS_VH

// opcodes handled here
`define SRRE_OP_PUSH 8'hc0
`define SRRE_OP_SUB_EXIT 8'h22
`define SRRE_OP_INT_EXIT 8'h32
`define SRRE_OP_ROT_LEFT 8'h23

// execution states
`define SRRE_ST_IDLE 2'h0
`define SRRE_ST_PUSH_WR 2'h1
`define SRRE_ST_POP_LO 2'h2

// reset values
`define SRRE_SP_RESET 8'h07
`define SRRE_PC_RESET 16'h0000
`define SRRE_ACC_RESET 8'h00
`define SRRE_PSW_RESET 8'h00
`define SRRE_LVL_RESET 2'h0

`endif

/* hw/srre_sp_step.v */
// eight-bit stack pointer step, plus or minus one
module srre_sp_step (
    input wire [7:0] value,
    input wire up,
    output wire [7:0] result
);
    // modulo 256 wrap falls out of the 8-bit width
    // wrap modulo 256
    assign result = up ? value + 8'h01 : value - 8'h01;
endmodule // srre_sp_step

/* hw/srre_exec.v */
`include "srre_regs.vh"

// execution unit for push, the two exits and rotate left
module srre_exec (
    // core clock
    input wire clk,
    // asynchronous reset, active low
    input wire nrst,
    // instruction offered by the decoder
    input wire instr_valid,
    // opcode byte
    input wire [7:0] instr_opcode,
    // second byte: direct address for push
    input wire [7:0] instr_operand,
    // unit can take an instruction
    output wire instr_ready,
    // one-cycle pulse when an instruction retires
    output reg exec_done,
    // one-cycle pulse for an opcode not handled here
    output reg exec_unsupported,
    // core loads the stack pointer
    input wire sp_load,
    // value for a stack pointer load
    input wire [7:0] sp_load_value,
    // core loads the program counter
    input wire pc_load,
    // value for a program counter load
    input wire [15:0] pc_load_value,
    // core loads the accumulator
    input wire acc_load,
    // value for an accumulator load
    input wire [7:0] acc_load_value,
    // core loads the status word
    input wire psw_load,
    // value for a status word load
    input wire [7:0] psw_load_value,
    // current stack pointer
    output reg [7:0] stack_pointer,
    // current program counter
    output reg [15:0] program_counter,
    // current accumulator
    output reg [7:0] acc,
    // current status word
    output reg [7:0] program_status_word,
    // pulse: fetch from fetch_addr
    output reg fetch_valid,
    // address of the next fetch
    output reg [15:0] fetch_addr,
    // internal ram address, combinational
    output reg [7:0] ram_addr,
    // internal ram write strobe, combinational
    output reg ram_wr,
    // internal ram write data
    output reg [7:0] ram_wdata,
    // internal ram read data, same cycle as ram_addr
    input wire [7:0] ram_rdata,
    // level of the interrupt in service
    input wire [1:0] isr_level,
    // pulse: re-arm interrupts at rearm_level
    output reg irq_rearm,
    // priority level being re-armed
    output reg [1:0] rearm_level,
    // a core instruction outside this unit retired
    input wire core_instr_done,
    // level: interrupt service must wait
    output reg irq_hold
);

    // execution state
    reg [1:0] state;
    // next execution state
    reg [1:0] next_state;
    // byte captured in the first cycle
    reg [7:0] held_byte;
    // the running pop belongs to interrupt exit
    reg pop_is_int;
    // stack pointer step direction
    reg sp_up;
    // stack pointer after one step
    wire [7:0] sp_stepped;
    // instruction accepted this cycle
    wire take;

    assign instr_ready = (state == `SRRE_ST_IDLE);
    assign take = instr_valid & instr_ready;

    // single adder for all stack pointer moves
    srre_sp_step u_sp_step (
        .value(stack_pointer),
        .up(sp_up),
        .result(sp_stepped)
    );

    // next state decode
    always @* begin
        next_state = state;
        case (state)
            // first cycle of a two-cycle instruction
            `SRRE_ST_IDLE: begin
                if (take) begin
                    if (instr_opcode == `SRRE_OP_PUSH) begin
                        next_state = `SRRE_ST_PUSH_WR;
                    end else if (instr_opcode == `SRRE_OP_SUB_EXIT ||
                                 instr_opcode == `SRRE_OP_INT_EXIT) begin
                        next_state = `SRRE_ST_POP_LO;
                    end
                end
            end
            // second cycles always return to idle
            `SRRE_ST_PUSH_WR: begin
                next_state = `SRRE_ST_IDLE;
            end
            `SRRE_ST_POP_LO: begin
                next_state = `SRRE_ST_IDLE;
            end
            default: begin
                next_state = `SRRE_ST_IDLE;
            end
        endcase
    end

    // ram port and step direction
    always @* begin
        ram_addr = stack_pointer;
        ram_wr = 1'b0;
        ram_wdata = held_byte;
        sp_up = 1'b0;
        case (state)
            `SRRE_ST_IDLE: begin
                // push reads its source by direct address
                if (take && instr_opcode == `SRRE_OP_PUSH) begin
                    ram_addr = instr_operand;
                    sp_up = 1'b1;
                end
            end
            `SRRE_ST_PUSH_WR: begin
                ram_addr = stack_pointer;
                ram_wr = 1'b1;
                ram_wdata = held_byte;
                sp_up = 1'b1;
            end
            // pop of the low byte at the lowered pointer
            `SRRE_ST_POP_LO: begin
                ram_addr = stack_pointer;
            end
            default: begin
                ram_addr = stack_pointer;
            end
        endcase
    end

    // state register
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= `SRRE_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // stack pointer register
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stack_pointer <= `SRRE_SP_RESET;
        end else if (state == `SRRE_ST_IDLE && take) begin
            if (instr_opcode == `SRRE_OP_PUSH) begin
                stack_pointer <= sp_stepped;
            end else if (instr_opcode == `SRRE_OP_SUB_EXIT ||
                         instr_opcode == `SRRE_OP_INT_EXIT) begin
                stack_pointer <= sp_stepped;
            end
        end else if (state == `SRRE_ST_POP_LO) begin
            stack_pointer <= sp_stepped;
        end else if (state == `SRRE_ST_IDLE && sp_load) begin
            // core load only in idle and when no instruction is taken this cycle
            stack_pointer <= sp_load_value;
        end
    end

    // byte held between the two cycles
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            held_byte <= 8'h00;
            pop_is_int <= 1'b0;
        end else if (take) begin
            held_byte <= ram_rdata;
            pop_is_int <= (instr_opcode == `SRRE_OP_INT_EXIT);
        end
    end

    // program counter and fetch request
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            program_counter <= `SRRE_PC_RESET;
            fetch_valid <= 1'b0;
            fetch_addr <= `SRRE_PC_RESET;
        end else begin
            fetch_valid <= 1'b0;
            if (state == `SRRE_ST_POP_LO) begin
                program_counter <= {held_byte, ram_rdata};
                fetch_valid <= 1'b1;
                fetch_addr <= {held_byte, ram_rdata};
            end else if (pc_load) begin
                program_counter <= pc_load_value;
            end
        end
    end

    // accumulator
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc <= `SRRE_ACC_RESET;
        end else if (take && instr_opcode == `SRRE_OP_ROT_LEFT) begin
            acc <= {acc[6:0], acc[7]};
        end else if (acc_load) begin
            acc <= acc_load_value;
        end
    end

    // status word: only the core ever writes it
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            program_status_word <= `SRRE_PSW_RESET;
        end else if (psw_load) begin
            program_status_word <= psw_load_value;
        end
    end

    // retire and unsupported pulses
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            exec_done <= 1'b0;
            exec_unsupported <= 1'b0;
        end else begin
            exec_done <= 1'b0;
            exec_unsupported <= 1'b0;
            if (state == `SRRE_ST_PUSH_WR || state == `SRRE_ST_POP_LO) begin
                // two-cycle instructions retire here
                exec_done <= 1'b1;
            end else if (take) begin
                if (instr_opcode == `SRRE_OP_ROT_LEFT) begin
                    exec_done <= 1'b1;
                end else if (instr_opcode != `SRRE_OP_PUSH &&
                             instr_opcode != `SRRE_OP_SUB_EXIT &&
                             instr_opcode != `SRRE_OP_INT_EXIT) begin
                    exec_unsupported <= 1'b1;
                end
            end
        end
    end

    // interrupt re-arm pulse with its level
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_rearm <= 1'b0;
            rearm_level <= `SRRE_LVL_RESET;
        end else begin
            irq_rearm <= 1'b0;
            if (state == `SRRE_ST_POP_LO && pop_is_int) begin
                irq_rearm <= 1'b1;
                rearm_level <= isr_level;
            end
        end
    end

    // hold service until one more instruction retires
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_hold <= 1'b0;
        end else if (state == `SRRE_ST_POP_LO && pop_is_int) begin
            irq_hold <= 1'b1;
        end else if ((core_instr_done || exec_done) && !irq_rearm) begin
            // next retire, not the exit's own
            irq_hold <= 1'b0;
        end
    end

endmodule // srre_exec

/* testbench/srre_ram_model.sv */
// internal data ram on the far side of the unit
module srre_ram_model (
    input logic clk,
    input logic [7:0] addr,
    input logic wr,
    input logic [7:0] wdata,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // stack and direct bytes, filled by the bench at time zero
    logic [7:0] mem [256];
    // asynchronous read, data valid in the addressing cycle
    assign rdata = mem[addr];
    // write lands at the rising edge
    always @(posedge clk) begin
        if (wr) begin
            mem[addr] <= wdata;
        end
    end
endmodule // srre_ram_model

/* testbench/srre_exec_checker.sv */
// timing checks at the ports of the execution unit
module srre_exec_checker (
    input logic clk,
    input logic nrst,
    input logic instr_valid,
    input logic [7:0] instr_opcode,
    input logic instr_ready,
    input logic exec_done,
    input logic psw_load,
    input logic [7:0] stack_pointer,
    input logic [15:0] program_counter,
    input logic [7:0] acc,
    input logic [7:0] program_status_word,
    input logic fetch_valid,
    input logic [15:0] fetch_addr,
    input logic [7:0] ram_addr,
    input logic ram_wr,
    input logic [7:0] ram_wdata,
    input logic [7:0] ram_rdata,
    input logic [1:0] isr_level,
    input logic irq_rearm,
    input logic [1:0] rearm_level,
    input logic core_instr_done,
    input logic irq_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // instruction taken at this edge
    wire tk = instr_valid && instr_ready;
    // either exit taken
    wire tx = tk && (instr_opcode == 8'h22 || instr_opcode == 8'h32);
    a_push_write: assert property (
        tk && instr_opcode == 8'hc0 |=> ram_wr && ram_addr == $past(stack_pointer) + 8'h01
        && ram_wdata == $past(ram_rdata)) else $error("push write wrong");
    a_push_time: assert property (
        tk && instr_opcode == 8'hc0 |=> !instr_ready ##1 exec_done) else $error("push time");
    a_exit_pop: assert property (
        tx |-> ram_addr == stack_pointer ##1 ram_addr == $past(stack_pointer) - 8'h01
        ##1 program_counter == {$past(ram_rdata, 2), $past(ram_rdata)}
        && stack_pointer == $past(stack_pointer, 2) - 8'h02) else $error("exit pop wrong");
    a_exit_fetch: assert property (
        tx |=> !instr_ready ##1 exec_done && fetch_valid && fetch_addr == program_counter)
        else $error("exit fetch wrong");
    a_rearm_level: assert property (
        tk && instr_opcode == 8'h32 |=> ##1 irq_rearm && irq_hold
        && rearm_level == $past(isr_level)) else $error("rearm wrong");
    a_psw_kept: assert property (
        !psw_load |=> $stable(program_status_word)) else $error("status word changed");
    a_rotate_left: assert property (
        tk && instr_opcode == 8'h23 |=> exec_done
        && acc == {$past(acc[6:0]), $past(acc[7])}) else $error("rotate wrong");
    a_hold_clear: assert property (
        irq_hold && instr_ready && !irq_rearm && (core_instr_done || exec_done)
        |=> !irq_hold) else $error("hold not cleared");
    a_hold_kept: assert property (
        irq_rearm |=> irq_hold) else $error("hold dropped on exit retire");
endmodule // srre_exec_checker

bind srre_exec srre_exec_checker chk (.clk, .nrst, .instr_valid, .instr_opcode,
    .instr_ready, .exec_done, .psw_load, .stack_pointer, .program_counter, .acc,
    .program_status_word, .fetch_valid, .fetch_addr, .ram_addr, .ram_wr, .ram_wdata,
    .ram_rdata, .isr_level, .irq_rearm, .rearm_level, .core_instr_done, .irq_hold);

/* testbench/tb_srre_exec.sv */
// self-checking bench for the execution unit
module tb_srre_exec;
    timeunit 1ns;
    timeprecision 1ps;
    // unit inputs, set at time zero
    logic clk, nrst, instr_valid, sp_load, pc_load, acc_load, psw_load, core_instr_done;
    logic [7:0] instr_opcode, instr_operand, sp_load_value, acc_load_value, psw_load_value;
    logic [15:0] pc_load_value;
    logic [1:0] isr_level;
    // unit outputs
    logic instr_ready, exec_done, exec_unsupported, fetch_valid, ram_wr, irq_rearm, irq_hold;
    logic [7:0] stack_pointer, acc, program_status_word, ram_addr, ram_wdata, ram_rdata;
    logic [15:0] program_counter, fetch_addr;
    logic [1:0] rearm_level;
    // bench state and shadow of the ram
    int error_cnt = 0, n_tests = 0, lat;
    logic [7:0] exp_mem [256];
    logic [7:0] sp, sp0, a, p, op;
    logic [15:0] e16;
    srre_exec dut (.clk, .nrst, .instr_valid, .instr_opcode, .instr_operand, .instr_ready,
        .exec_done, .exec_unsupported, .sp_load, .sp_load_value, .pc_load, .pc_load_value,
        .acc_load, .acc_load_value, .psw_load, .psw_load_value, .stack_pointer,
        .program_counter, .acc, .program_status_word, .fetch_valid, .fetch_addr, .ram_addr,
        .ram_wr, .ram_wdata, .ram_rdata, .isr_level, .irq_rearm, .rearm_level,
        .core_instr_done, .irq_hold);
    srre_ram_model ram (.clk, .addr(ram_addr), .wr(ram_wr), .wdata(ram_wdata),
        .rdata(ram_rdata));
    // 200 mhz clock
    always #2.5 clk = ~clk;
    // verdict and end of run
    task close_out;
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // compare one value
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (e !== g) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // offer one instruction, count edges until it retires
    task run(input logic [7:0] o, input logic [7:0] d);
        instr_valid <= 1'h1;
        instr_opcode <= o;
        instr_operand <= d;
        do @(posedge clk); while (instr_ready !== 1'h1);
        instr_valid <= 1'h0;
        lat = 0;
        do begin
            @(posedge clk);
            lat++;
        end while (exec_done !== 1'h1 && exec_unsupported !== 1'h1 && lat < 8);
    endtask
    // core loads of pointer, status word and accumulator
    task ld(input logic [7:0] s, input logic [7:0] ps, input logic [7:0] ac);
        {sp_load, psw_load, acc_load} <= 3'h7;
        sp_load_value <= s;
        psw_load_value <= ps;
        acc_load_value <= ac;
        @(posedge clk);
        {sp_load, psw_load, acc_load} <= 3'h0;
        @(posedge clk);
        sp = s;
    endtask
    // push one direct byte and follow it in the shadow
    task push(input logic [7:0] s);
        run(8'hc0, s);
        sp = sp + 8'h01;
        exp_mem[sp] = exp_mem[s];
        chk("push lat", 16'h0002, lat);
        chk("push sp", sp, stack_pointer);
        chk("push ram", exp_mem[sp], ram.mem[sp]);
    endtask
    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    // main sequence
    initial begin
        {clk, nrst, instr_valid, sp_load, pc_load, acc_load, psw_load, core_instr_done} = '0;
        {instr_opcode, instr_operand, sp_load_value, acc_load_value, psw_load_value} = '0;
        pc_load_value = '0;
        isr_level = '0;
        void'($urandom(23));
        for (int i = 0; i < 256; i++) begin
            exp_mem[i] = $urandom;
            ram.mem[i] = exp_mem[i];
        end
        repeat (20) @(posedge clk);
        chk("sp reset", 16'h0007, stack_pointer);
        chk("psw reset", 16'h0000, program_status_word);
        nrst <= 1'h1;
        @(posedge clk);
        // pointer wraps from ff to 00
        ld(8'hff, 8'h00, 8'h00);
        push(8'h30);
        // two pushes then an exit, both exit kinds
        for (int i = 0; i < 12; i++) begin
            ld($urandom, $urandom, $urandom);
            sp0 = sp;
            p = psw_load_value;
            push($urandom);
            push($urandom);
            op = i[0] ? 8'h32 : 8'h22;
            isr_level <= $urandom;
            e16 = {exp_mem[sp], exp_mem[sp - 8'h01]};
            run(op, 8'h00);
            chk("exit lat", 16'h0002, lat);
            chk("pc", e16, program_counter);
            chk("fetch addr", e16, fetch_addr);
            chk("fetch valid", 16'h0001, fetch_valid);
            chk("exit sp", sp0, stack_pointer);
            chk("exit psw", p, program_status_word);
            chk("rearm", i[0], irq_rearm);
            if (i[0]) begin
                chk("rearm level", isr_level, rearm_level);
                chk("hold set", 16'h0001, irq_hold);
                core_instr_done <= 1'h1;
                @(posedge clk);
                chk("hold kept", 16'h0001, irq_hold);
                core_instr_done <= 1'h0;
                @(posedge clk);
                chk("hold clear", 16'h0000, irq_hold);
            end
        end
        // back to back rotates, corner value first
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 8'hc5 : $urandom;
            p = $urandom;
            ld(stack_pointer, p, a);
            run(8'h23, 8'h00);
            chk("rot once", {a[6:0], a[7]}, acc);
            run(8'h23, 8'h00);
            chk("rot lat", 16'h0001, lat);
            chk("rot twice", {a[5:0], a[7:6]}, acc);
            chk("rot psw", p, program_status_word);
        end
        // opcodes outside this unit, fixed one first
        for (int i = 0; i < 4; i++) begin
            op = (i == 0) ? 8'hd0 : $urandom;
            if (op == 8'hc0 || op == 8'h22 || op == 8'h32 || op == 8'h23) op = 8'hd0;
            run(op, $urandom);
            chk("unsup lat", 16'h0001, lat);
            chk("unsup flag", 16'h0001, exec_unsupported);
            chk("unsup done", 16'h0000, exec_done);
            chk("unsup sp", sp, stack_pointer);
        end
        close_out();
    end
endmodule // tb_srre_exec
